/* src/rtc_alarm_pkg.sv */
// Constants, register map and types for the dual calendar alarm block
package rtc_alarm_pkg;
    // Clock and kernel timing
    localparam int unsigned CLK_HZ         = 20_000_000;
    localparam int unsigned KERNEL_HZ      = 32_768;
    localparam int unsigned KERNEL_DIV     = CLK_HZ / KERNEL_HZ;
    localparam int unsigned KDIV_W         = 10;
    localparam logic [1:0]  WRITE_OK_TICKS = 2'h2;
    // Register bus
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    localparam logic [7:0]  OFS_CTRL  = 8'h08;
    localparam logic [7:0]  OFS_STAT  = 8'h0C;
    localparam logic [7:0]  OFS_ALRMA = 8'h1C;
    localparam logic [7:0]  OFS_ALRMB = 8'h20;
    localparam logic [7:0]  OFS_WPKEY = 8'h24;
    // Write protection keys
    localparam logic [7:0]  KEY_FIRST  = 8'hCA;
    localparam logic [7:0]  KEY_SECOND = 8'h53;
    localparam logic [7:0]  KEY_LOCK   = 8'hFF;
    // clock_control_reg fields
    localparam int unsigned CTRL_W        = 8;
    localparam int unsigned CTRL_FMT      = 0;
    localparam int unsigned CTRL_EN_LSB   = 1;
    localparam int unsigned CTRL_IE_LSB   = 3;
    localparam int unsigned CTRL_OSEL_LSB = 5;
    localparam int unsigned CTRL_POL      = 7;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [1:0]  OSEL_A        = 2'h1;
    localparam logic [1:0]  OSEL_B        = 2'h2;
    // init_status_reg fields
    localparam int unsigned STAT_WOK_LSB  = 0;
    localparam int unsigned STAT_FLAG_LSB = 8;
    // Calendar time / alarm match fields, shared layout
    localparam int unsigned TIME_W    = 23;
    localparam int unsigned SEC_LSB   = 0;
    localparam int unsigned MIN_LSB   = 8;
    localparam int unsigned HOUR_LSB  = 16;
    localparam int unsigned FIELD_W   = 7;
    localparam int unsigned DAY_LSB   = 24;
    localparam int unsigned DATE_W    = 6;
    localparam int unsigned WDAY_W    = 3;
    localparam int unsigned WEEKDAY_SELECT_POS = 30;
    localparam int unsigned MSK_SEC_POS  = 7;
    localparam int unsigned MSK_MIN_POS  = 15;
    localparam int unsigned MSK_HOUR_POS = 23;
    localparam int unsigned MSK_DAY_POS  = 31;
    localparam logic [31:0] MATCH_RST = 32'h0000_0000;
    // Key sequence states
    typedef enum logic [1:0] {
        KEY_LOCKED = 2'h0,
        KEY_HALF   = 2'h1,
        KEY_OPEN   = 2'h3
    } key_state_t;
endpackage

/* src/alarm_if.sv */
// Signals between the register side and one alarm compare unit
`timescale 1ns/1ps
interface alarm_if;
    import rtc_alarm_pkg::*;
    logic [31:0]       match;
    logic              enable;
    logic              kernel_tick;
    logic              sec_tick;
    logic [TIME_W-1:0] cal_time;
    logic [WDAY_W-1:0] cal_weekday;
    logic [DATE_W-1:0] cal_date;
    logic              hit;
    logic              write_ok;
    modport unit (input  match, enable, kernel_tick, sec_tick,
                  input  cal_time, cal_weekday, cal_date,
                  output hit, write_ok);
    modport ctrl (output match, enable, kernel_tick, sec_tick,
                  output cal_time, cal_weekday, cal_date,
                  input  hit, write_ok);
endinterface

/* src/alarm_unit.sv */
// One alarm compare unit with its write-allowed synchroniser
`timescale 1ns/1ps
module alarm_unit
    import rtc_alarm_pkg::*;
(
    // Clock and reset
    input  logic   clk_i,
    input  logic   nrst_i,
    // Register side
    alarm_if.unit  bus
);
    logic       hit_r, hit_nxt;
    logic [1:0] wcnt_r, wcnt_nxt;
    logic [3:0] mask;
    logic       day_eq;
    logic       all_ok;

    function automatic logic field_ok(input logic ignore, input logic eq);
        return ignore | eq;
    endfunction

    // Bit 0 seconds .. bit 3 day
    assign mask = {bus.match[MSK_DAY_POS], bus.match[MSK_HOUR_POS],
                   bus.match[MSK_MIN_POS], bus.match[MSK_SEC_POS]}; // [RULE_13]
    // Day units hold the weekday in the low bits, upper bit zero
    assign day_eq = bus.match[WEEKDAY_SELECT_POS]
        ? (bus.match[DAY_LSB +: WDAY_W+1] == {1'b0, bus.cal_weekday}) // [RULE_15]
        : (bus.match[DAY_LSB +: DATE_W] == bus.cal_date);
    // Plain BCD bit compare; PM bit sits inside the hour field
    assign all_ok =
        field_ok(mask[0], bus.match[SEC_LSB +: FIELD_W] == bus.cal_time[SEC_LSB +: FIELD_W])
      & field_ok(mask[1], bus.match[MIN_LSB +: FIELD_W] == bus.cal_time[MIN_LSB +: FIELD_W])
      & field_ok(mask[2], bus.match[HOUR_LSB +: FIELD_W] == bus.cal_time[HOUR_LSB +: FIELD_W])
      & field_ok(mask[3], day_eq); // [RULE_02] [RULE_05] [RULE_14] [RULE_17]

    always_comb begin
        // One event per second update, only while enabled
        hit_nxt  = bus.enable & bus.sec_tick & all_ok; // [RULE_06] [RULE_12] [RULE_20]
        wcnt_nxt = wcnt_r;
        if (bus.enable) begin
            wcnt_nxt = 2'h0;
        end else if (bus.kernel_tick && wcnt_r != WRITE_OK_TICKS) begin
            wcnt_nxt = wcnt_r + 2'h1; // [RULE_10]
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hit_r  <= 1'b0;
            wcnt_r <= 2'h0;
        end else begin
            hit_r  <= hit_nxt;
            wcnt_r <= wcnt_nxt;
        end
    end

    assign bus.hit      = hit_r;
    assign bus.write_ok = (wcnt_r == WRITE_OK_TICKS);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_hit_cause;
        hit_r |-> $past(bus.sec_tick) && $past(bus.enable);
    endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("hit without tick"); // [RULE_20]
    property p_all_masked;
        bus.enable && bus.sec_tick && (&mask) |=> hit_r;
    endproperty
    a_all_masked: assert property (p_all_masked) else $error("masked alarm missed"); // [RULE_13]
    property p_exact_miss;
        bus.enable && bus.sec_tick && mask == 4'h0
            && bus.match[SEC_LSB +: FIELD_W] != bus.cal_time[SEC_LSB +: FIELD_W] |=> !hit_r;
    endproperty
    a_exact_miss: assert property (p_exact_miss) else $error("seconds ignored"); // [RULE_14]
    property p_wok_rise;
        $rose(bus.write_ok) |-> $past(bus.kernel_tick) && !$past(bus.enable, 2);
    endproperty
    a_wok_rise: assert property (p_wok_rise) else $error("write_ok early"); // [RULE_10]
    property p_wok_drop;
        bus.enable |=> !bus.write_ok;
    endproperty
    a_wok_drop: assert property (p_wok_drop) else $error("write_ok while enabled"); // [RULE_10]
endmodule

/* src/wp_key_lock.sv */
// Write protection key sequence
`timescale 1ns/1ps
module wp_key_lock
    import rtc_alarm_pkg::*;
(
    // Clock and reset
    input  logic       clk_i,
    input  logic       nrst_i,
    // Key register write
    input  logic       key_wr_i,
    input  logic [7:0] key_i,
    // Unlock state
    output logic       unlocked_o
);
    key_state_t state_r, state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (key_wr_i) begin
            unique case (state_r)
                KEY_LOCKED: state_nxt = (key_i == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
                KEY_HALF:   state_nxt = (key_i == KEY_SECOND) ? KEY_OPEN : KEY_LOCKED; // [RULE_07]
                // Any key write while open locks again, 0xFF included
                KEY_OPEN:   state_nxt = KEY_LOCKED; // [RULE_08]
                default:    state_nxt = KEY_LOCKED;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= KEY_LOCKED;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign unlocked_o = (state_r == KEY_OPEN);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_first_key;
        key_wr_i && key_i == KEY_FIRST && state_r == KEY_LOCKED;
    endsequence
    sequence s_second_key;
        key_wr_i && key_i == KEY_SECOND;
    endsequence
    property p_unlock_pair;
        s_first_key ##1 s_second_key |=> unlocked_o;
    endproperty
    a_unlock_pair: assert property (p_unlock_pair) else $error("key pair no unlock"); // [RULE_07]
    property p_relock;
        key_wr_i && key_i == KEY_LOCK |=> !unlocked_o;
    endproperty
    a_relock: assert property (p_relock) else $error("lock key ignored"); // [RULE_08]
    property p_open_cause;
        $rose(unlocked_o) |-> $past(key_wr_i) && $past(key_i) == KEY_SECOND;
    endproperty
    a_open_cause: assert property (p_open_cause) else $error("unlock without key"); // [RULE_07]
endmodule

/* src/rtc_calendar_alarm_pair.sv */
// Dual calendar alarm with register port, key lock and alarm output pin
// Summary of operation
// RULE_01: Two identical alarm units, each with match register, enable, write-ok and flag.
// RULE_02: Each unit compares seconds, minutes, hours and day; each field can be excluded.
// RULE_03: Selected alarm flag drives the alarm pin with programmable polarity.
// RULE_04: Each alarm has its own flag, interrupt request and wakeup contribution.
// RULE_05: Match register time fields use the calendar time register layout.
// RULE_06: All unmasked fields equal the calendar: the alarm flag is set.
// RULE_07: Protected registers unlock only after key 0xCA then 0x53.
// RULE_08: Key 0xFF locks the protected registers again.
// RULE_09: Match register writes only when its alarm is disabled or in init mode.
// RULE_10: Write-ok flag rises two kernel ticks after the enable is cleared.
// RULE_11: Software programs the alarm hour in the calendar's own hour format.
// RULE_12: Setting the enable again resumes comparison for that alarm.
// RULE_13: Mask bits 0..3 drop seconds, minutes, hours, day from the compare.
// RULE_14: All mask bits clear: match only at the exact time and day.
// RULE_15: Weekday select picks weekday compare when set, date compare when clear.
// RULE_16: Software keeps the sync divider at 3 or more when seconds compare.
// RULE_17: Calendar fields arrive and are compared as BCD.
// RULE_18: Hour format bit: 0 is 24-hour, 1 is 12-hour with AM/PM.
// RULE_19: Alarm flag stays set until software clears it.
// RULE_20: Compare is evaluated once per calendar second update.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
module rtc_calendar_alarm_pair
    import rtc_alarm_pkg::*;
(
    // Clock and reset
    input  logic               clk_i,
    input  logic               nrst_i,
    // Register port
    input  logic [ADDR_W-1:0]  addr_i,
    input  logic [DATA_W-1:0]  wdata_i,
    input  logic               wr_i,
    input  logic               rd_i,
    output logic [DATA_W-1:0]  rdata_o,
    // Calendar side
    input  logic [TIME_W-1:0]  cal_time_i,
    input  logic [WDAY_W-1:0]  cal_weekday_i,
    input  logic [DATE_W-1:0]  cal_date_i,
    input  logic               sec_tick_i,
    input  logic               init_mode_i,
    output logic               hour_format_o,
    // Alarm outputs
    output logic               irq_a_o,
    output logic               irq_b_o,
    output logic               wakeup_o,
    output logic               alarm_pin_o
);
    logic [KDIV_W-1:0]      kdiv_r, kdiv_nxt;
    logic                   ktick_r, ktick_nxt;
    logic [CTRL_W-1:0]      ctrl_r, ctrl_nxt;
    logic [1:0][DATA_W-1:0] match_r, match_nxt;
    logic [1:0]             flag_r, flag_nxt;
    logic [1:0]             irq_r, irq_nxt;
    logic                   wake_r, wake_nxt;
    logic                   pin_r, pin_nxt;
    logic                   pin_active;
    logic [DATA_W-1:0]      rdata_r, rdata_nxt;
    logic [1:0]             hit_w;
    logic [1:0]             wok_w;
    logic                   unlocked;
    logic [1:0]             osel;

    function automatic logic [7:0] match_ofs(input int unsigned idx);
        return (idx == 0) ? OFS_ALRMA : OFS_ALRMB;
    endfunction

    // Kernel clock rate as an enable pulse
    always_comb begin
        kdiv_nxt  = KDIV_W'(kdiv_r + 1'b1);
        ktick_nxt = 1'b0;
        if (kdiv_r == KDIV_W'(KERNEL_DIV - 1)) begin
            kdiv_nxt  = '0;
            ktick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            kdiv_r  <= '0;
            ktick_r <= 1'b0;
        end else begin
            kdiv_r  <= kdiv_nxt;
            ktick_r <= ktick_nxt;
        end
    end

    wp_key_lock u_key (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .key_wr_i   (wr_i && addr_i == OFS_WPKEY),
        .key_i      (wdata_i[7:0]),
        .unlocked_o (unlocked)
    );

    // Two identical compare units
    for (genvar g = 0; g < 2; g++) begin : g_unit
        alarm_if aif ();
        assign aif.match       = match_r[g];
        assign aif.enable      = ctrl_r[CTRL_EN_LSB + g];
        assign aif.kernel_tick = ktick_r;
        assign aif.sec_tick    = sec_tick_i;
        assign aif.cal_time    = cal_time_i;
        assign aif.cal_weekday = cal_weekday_i;
        assign aif.cal_date    = cal_date_i;
        assign hit_w[g]        = aif.hit;
        assign wok_w[g]        = aif.write_ok;
        alarm_unit u_alarm (
            .clk_i  (clk_i),
            .nrst_i (nrst_i),
            .bus    (aif.unit)
        ); // [RULE_01]
    end

    assign osel       = ctrl_r[CTRL_OSEL_LSB +: 2];
    // Select 11 is spare and keeps the pin at its idle level
    always_comb begin
        case (osel)
            OSEL_A:  pin_active = flag_r[0];
            OSEL_B:  pin_active = flag_r[1];
            default: pin_active = 1'b0;
        endcase
    end

    always_comb begin
        ctrl_nxt  = ctrl_r;
        match_nxt = match_r;
        flag_nxt  = flag_r;
        rdata_nxt = '0;
        if (wr_i && unlocked && addr_i == OFS_CTRL) begin
            ctrl_nxt = wdata_i[CTRL_W-1:0]; // [RULE_07] [RULE_12] [RULE_18]
        end
        for (int g = 0; g < 2; g++) begin
            // Match write needs the key and a stopped alarm or init mode
            if (wr_i && unlocked && addr_i == match_ofs(g)
                && (!ctrl_r[CTRL_EN_LSB + g] || init_mode_i)) begin
                match_nxt[g] = wdata_i; // [RULE_07] [RULE_09]
            end
            // Flag clear writes zero; a same-cycle hit wins
            if (wr_i && addr_i == OFS_STAT && !wdata_i[STAT_FLAG_LSB + g]) begin
                flag_nxt[g] = 1'b0;
            end
            if (hit_w[g]) begin
                flag_nxt[g] = 1'b1; // [RULE_06] [RULE_19]
            end
            irq_nxt[g] = flag_r[g] & ctrl_r[CTRL_IE_LSB + g]; // [RULE_04]
        end
        wake_nxt = |irq_r; // [RULE_04]
        // Polarity bit set means active low
        pin_nxt  = pin_active ^ ctrl_r[CTRL_POL]; // [RULE_03]
        if (rd_i) begin
            case (addr_i)
                OFS_CTRL: rdata_nxt[CTRL_W-1:0] = ctrl_r;
                OFS_STAT: begin
                    rdata_nxt[STAT_WOK_LSB +: 2]  = wok_w; // [RULE_10]
                    rdata_nxt[STAT_FLAG_LSB +: 2] = flag_r;
                end
                OFS_ALRMA: rdata_nxt = match_r[0];
                OFS_ALRMB: rdata_nxt = match_r[1];
                default:   rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_r  <= CTRL_RST;
            match_r <= {MATCH_RST, MATCH_RST};
            flag_r  <= 2'h0;
            irq_r   <= 2'h0;
            wake_r  <= 1'b0;
            pin_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            match_r <= match_nxt;
            flag_r  <= flag_nxt;
            irq_r   <= irq_nxt;
            wake_r  <= wake_nxt;
            pin_r   <= pin_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Calendar uses this to pick 24-hour or AM/PM counting
    assign hour_format_o = ctrl_r[CTRL_FMT]; // [RULE_18]
    assign irq_a_o       = irq_r[0];
    assign irq_b_o       = irq_r[1];
    assign wakeup_o      = wake_r;
    assign alarm_pin_o   = pin_r;
    assign rdata_o       = rdata_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_flag_set;
        hit_w[1] |=> flag_r[1];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag B not set"); // [RULE_06]

    property p_flag_a_set;
        hit_w[0]
            |=> flag_r[0];
    endproperty
    a_flag_a_set: assert property (p_flag_a_set) else $error("flag A not set"); // [RULE_06]

    property p_flag_sticky;
        flag_r[0] && !(wr_i && addr_i == OFS_STAT && !wdata_i[STAT_FLAG_LSB]) |=> flag_r[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag A lost"); // [RULE_19]

    property p_flag_clear;
        wr_i && addr_i == OFS_STAT && !wdata_i[STAT_FLAG_LSB + 1] && !hit_w[1]
            |=> !flag_r[1];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag B not cleared"); // [RULE_19]

    property p_locked_ctrl;
        wr_i && addr_i == OFS_CTRL && !unlocked |=> $stable(ctrl_r);
    endproperty
    a_locked_ctrl: assert property (p_locked_ctrl) else $error("locked write took"); // [RULE_07]

    property p_ctrl_open;
        wr_i && unlocked && addr_i == OFS_CTRL
            |=> ctrl_r == $past(wdata_i[CTRL_W-1:0]);
    endproperty
    a_ctrl_open: assert property (p_ctrl_open) else $error("open write lost"); // [RULE_07]

    property p_match_guard;
        wr_i && addr_i == OFS_ALRMA && ctrl_r[CTRL_EN_LSB] && !init_mode_i
            |=> $stable(match_r[0]);
    endproperty
    a_match_guard: assert property (p_match_guard) else $error("match A written live"); // [RULE_09]

    property p_match_init;
        wr_i && unlocked && addr_i == OFS_ALRMA && init_mode_i
            |=> match_r[0] == $past(wdata_i);
    endproperty
    a_match_init: assert property (p_match_init) else $error("init write lost"); // [RULE_09]

    property p_match_take;
        wr_i && unlocked && addr_i == OFS_ALRMB && !ctrl_r[CTRL_EN_LSB + 1]
            |=> match_r[1] == $past(wdata_i);
    endproperty
    a_match_take: assert property (p_match_take) else $error("match B not written"); // [RULE_09]

    sequence s_flag_and_ie;
        flag_r[1] && ctrl_r[CTRL_IE_LSB + 1];
    endsequence
    property p_irq_wake;
        s_flag_and_ie ##1 s_flag_and_ie |=> irq_b_o && wakeup_o;
    endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("irq or wakeup missing"); // [RULE_04]

    property p_irq_a;
        flag_r[0] && ctrl_r[CTRL_IE_LSB]
            |=> irq_a_o;
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("irq A missing"); // [RULE_04]

    property p_irq_off;
        !flag_r[1]
            |=> !irq_b_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq B without flag"); // [RULE_04]

    property p_wake_cause;
        $rose(wakeup_o)
            |-> $past(irq_r) != 2'h0;
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("wakeup without irq"); // [RULE_04]

    property p_pin_low_active;
        osel == OSEL_A && ctrl_r[CTRL_POL] && flag_r[0] |=> !alarm_pin_o;
    endproperty
    a_pin_low_active: assert property (p_pin_low_active) else $error("pin polarity wrong"); // [RULE_03]

    property p_pin_b_high;
        osel == OSEL_B && !ctrl_r[CTRL_POL]
            |=> alarm_pin_o == $past(flag_r[1]);
    endproperty
    a_pin_b_high: assert property (p_pin_b_high) else $error("pin B wrong"); // [RULE_03]

    property p_pin_none;
        osel != OSEL_A && osel != OSEL_B
            |=> alarm_pin_o == $past(ctrl_r[CTRL_POL]);
    endproperty
    a_pin_none: assert property (p_pin_none) else $error("pin active unselected"); // [RULE_03]

    // Kernel rate is a single-cycle enable, never a level
    property p_ktick_gap;
        ktick_r
            |=> !ktick_r;
    endproperty
    a_ktick_gap: assert property (p_ktick_gap) else $error("kernel tick held"); // [RULE_10]

    property p_rd_unmapped;
        rd_i && addr_i == OFS_WPKEY |=> rdata_o == '0;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("key reg read nonzero");

    // Read data stands one cycle only, so a stale word never aliases
    property p_rdata_idle;
        !rd_i
            |=> rdata_o == '0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data held");
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the dual calendar alarm block
`timescale 1ns/1ps
module tb_top;
    import rtc_alarm_pkg::*;
    typedef struct {
        logic [31:0] val;
        logic [31:0] msk;
    } note_t;
    // Design ports
    logic              clk_i = 1'b0;
    logic              nrst_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic              wr_i = 1'b0;
    logic              rd_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [TIME_W-1:0] cal_time_i = '0;
    logic [WDAY_W-1:0] cal_weekday_i = 3'h1;
    logic [DATE_W-1:0] cal_date_i = 6'h01;
    logic              sec_tick_i = 1'b0;
    logic              init_mode_i = 1'b0;
    logic              hour_format_o;
    logic              irq_a_o;
    logic              irq_b_o;
    logic              wakeup_o;
    logic              alarm_pin_o;
    // Bench state
    note_t             notes[$];
    note_t             nt;
    logic              rd_seen = 1'b0;
    int                err_total = 0;
    int                compares = 0;
    int                cycles = 0;
    int                s, mi, h, w, dt;
    logic [3:0]        m, eq;
    logic              u, ws, pm, hit;
    logic [5:0]        day;
    logic [31:0]       alm;
    logic [7:0]        ua;

    rtc_calendar_alarm_pair rtc_calendar_alarm_pair_i (
        .clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .cal_time_i, .cal_weekday_i, .cal_date_i, .sec_tick_i, .init_mode_i,
        .hour_format_o, .irq_a_o, .irq_b_o, .wakeup_o, .alarm_pin_o
    );

    always #25 clk_i = ~clk_i;

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_seen) begin
            nt = notes.pop_front();
            check("read data", rdata_o & nt.msk, nt.val & nt.msk);
        end
        rd_seen <= rd_i;
    end

    // Limit well above the expected run of about 3800 cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            err_total++;
            $display("wrong value cycle limit expected 0 seen %0d", cycles);
            finish_test();
        end
    end

    task automatic idle(int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] mk);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        notes.push_back('{e, mk});
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    task automatic key(logic [7:0] k);
        wr(OFS_WPKEY, {24'h0, k});
    endtask

    task automatic tick();
        @(posedge clk_i);
        sec_tick_i <= 1'b1;
        @(posedge clk_i);
        sec_tick_i <= 1'b0;
    endtask

    function automatic logic [7:0] bcd(int v);
        return 8'((v / 10) * 16 + v % 10);
    endfunction

    // Any value in 0..n-1 other than v
    function automatic int oth(int v, int n);
        return (v + 1 + $urandom % (n - 1)) % n;
    endfunction

    function automatic logic [31:0] ctl(logic [1:0] en, logic [1:0] ie,
                                        logic [1:0] os, logic pol);
        return {24'h0, pol, os, ie, en, 1'b0};
    endfunction

    initial begin
        void'($urandom(32'h38E1FD08));
        idle(8);
        nrst_i <= 1'b1;
        rd(OFS_CTRL, CTRL_RST, '1);
        rd(OFS_STAT, 32'h0, '1);
        rd(OFS_ALRMA, MATCH_RST, '1);
        rd(OFS_ALRMB, MATCH_RST, '1);
        rd(8'h04, 32'h0, '1);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h0, '1);
        key(KEY_FIRST);
        key(8'h12);
        key(KEY_SECOND);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h0, '1);
        key(KEY_FIRST);
        key(KEY_SECOND);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h1, '1);
        @(negedge clk_i);
        check("hour format", 32'(hour_format_o), 32'h1);
        key(KEY_LOCK);
        wr(OFS_CTRL, 32'h0);
        rd(OFS_CTRL, 32'h1, '1);
        key(KEY_FIRST);
        key(KEY_SECOND);
        wr(OFS_CTRL, 32'h0);
        @(negedge clk_i);
        check("hour format", 32'(hour_format_o), 32'h0);
        $display("test lock done");

        idle(1300);
        rd(OFS_STAT, 32'h3, '1);
        wr(OFS_CTRL, ctl(2'b01, 2'b00, 2'b00, 1'b0));
        rd(OFS_STAT, 32'h0, 32'h1);
        wr(OFS_ALRMA, 32'h0012_3456);
        rd(OFS_ALRMA, MATCH_RST, '1);
        @(posedge clk_i);
        init_mode_i <= 1'b1;
        wr(OFS_ALRMA, 32'h0012_3456);
        init_mode_i <= 1'b0;
        rd(OFS_ALRMA, 32'h0012_3456, '1);
        wr(OFS_CTRL, 32'h0);
        idle(590);
        rd(OFS_STAT, 32'h0, 32'h1);
        idle(660);
        rd(OFS_STAT, 32'h1, 32'h1);
        $display("test write access done");

        // Every mask code on both units, field equality chosen per field
        for (int k = 0; k < 64; k++) begin
            u = k[0];
            m = 4'(k >> 1);
            eq = (k >= 32) ? 4'hF : 4'($urandom);
            ws = 1'($urandom);
            pm = 1'($urandom);
            s = $urandom % 60;
            mi = $urandom % 60;
            h = $urandom % 24;
            w = 1 + $urandom % 7;
            dt = 1 + $urandom % 31;
            day = ws ? 6'(w) : 6'(bcd(dt));
            alm = {m[3], ws, day, m[2], pm, 6'(bcd(h)), m[1], 7'(bcd(mi)),
                   m[0], 7'(bcd(s))};
            ua = u ? OFS_ALRMB : OFS_ALRMA;
            wr(OFS_CTRL, 32'h0);
            wr(ua, alm);
            rd(ua, alm, '1);
            // Pin watches alarm A in both halves
            wr(OFS_CTRL, u ? 32'h24 : 32'h22);
            // Hour mismatch flips only the PM bit
            cal_time_i <= {pm ^ ~eq[2], 6'(bcd(h)), 1'b0,
                           7'(bcd(eq[1] ? mi : oth(mi, 60))), 1'b0,
                           7'(bcd(eq[0] ? s : oth(s, 60)))};
            cal_weekday_i <= 3'((ws && eq[3]) ? w : 1 + oth(w - 1, 7));
            cal_date_i <= 6'(bcd((!ws && eq[3]) ? dt : 1 + oth(dt - 1, 31)));
            tick();
            idle(3);
            hit = &(eq | m);
            rd(OFS_STAT, 32'(hit) << (STAT_FLAG_LSB + u), 32'h300);
            @(negedge clk_i);
            check("irq without enable", 32'({irq_a_o, irq_b_o}), 32'h0);
            check("alarm pin A", 32'(alarm_pin_o), 32'(hit & ~u));
            wr(OFS_STAT, 32'h0);
        end
        $display("test mask compare done");

        wr(OFS_CTRL, ctl(2'b00, 2'b10, OSEL_B, 1'b1));
        wr(OFS_ALRMB, 32'h8080_8080);
        tick();
        idle(5);
        rd(OFS_STAT, 32'h0, 32'h300);
        @(negedge clk_i);
        check("alarm pin", 32'(alarm_pin_o), 32'h1);
        wr(OFS_CTRL, ctl(2'b10, 2'b10, OSEL_B, 1'b1));
        tick();
        idle(5);
        @(negedge clk_i);
        check("irq b", 32'(irq_b_o), 32'h1);
        check("wakeup", 32'(wakeup_o), 32'h1);
        check("alarm pin", 32'(alarm_pin_o), 32'h0);
        check("irq a", 32'(irq_a_o), 32'h0);
        tick();
        wr(OFS_STAT, 32'h200);
        rd(OFS_STAT, 32'h200, 32'h300);
        wr(OFS_CTRL, ctl(2'b10, 2'b10, OSEL_B, 1'b0));
        wr(OFS_STAT, 32'h0);
        idle(5);
        @(negedge clk_i);
        check("wakeup", 32'(wakeup_o), 32'h0);
        check("alarm pin", 32'(alarm_pin_o), 32'h0);
        tick();
        idle(5);
        @(negedge clk_i);
        check("alarm pin", 32'(alarm_pin_o), 32'h1);
        $display("test outputs done");
        idle(4);
        finish_test();
    end
endmodule
